// file: hw/gtc_timer_core.sv
`timescale 1ns/1ps
// Gated 16-bit up-counter with APB register access
module gtc_timer_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock and gate inputs from outside this domain
  input wire logic ext_clock_pin,
  input wire logic low_freq_internal_osc,
  input wire logic gate_input,
  // Core power state, same clock
  input wire logic sleep_mode,
  // Status outputs
  output logic overflow_flag,
  output logic wake_req,
  output logic secondary_osc_enable
);

  ////////////////////////////////////////////////////////////////
  // Registers
  gtc_pkg::gtc_ctrl_t ctrl;   // Timer control register
  gtc_pkg::gtc_gate_t gate;   // Gate control register
  logic [15:0] count;         // Live count
  logic [1:0] div4;           // Instruction clock divider
  logic armed;                // Pin falling edge seen
  logic [2:0] sync1;          // First synchroniser stage
  logic [2:0] sync2;          // Second synchroniser stage
  logic [2:0] sync3;          // Edge history stage
  logic pin_s4;               // Extra stage of the sync pin path

  ////////////////////////////////////////////////////////////////
  // APB decode
  wire [2:0] raw_in;
  wire setup_done;
  wire done;
  wire wr_done;
  wire hit_lo;
  wire hit_hi;
  wire hit_ctrl;
  wire hit_gate;
  wire hit_stat;
  wire hit_any;
  wire lo_wr;
  wire hi_wr;
  wire cnt_wr;
  wire ovf_clr;

  // Exact word match on a register offset
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : addr_is

  assign setup_done = psel && penable && !pready;
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign hit_lo = addr_is(paddr, gtc_pkg::ADDR_CNT_LO);
  assign hit_hi = addr_is(paddr, gtc_pkg::ADDR_CNT_HI);
  assign hit_ctrl = addr_is(paddr, gtc_pkg::ADDR_CTRL);
  assign hit_gate = addr_is(paddr, gtc_pkg::ADDR_GATE);
  assign hit_stat = addr_is(paddr, gtc_pkg::ADDR_STAT);
  assign hit_any = hit_lo || hit_hi || hit_ctrl || hit_gate || hit_stat;
  assign lo_wr = wr_done && hit_lo;
  assign hi_wr = wr_done && hit_hi;
  assign cnt_wr = lo_wr || hi_wr;
  assign ovf_clr = wr_done && hit_stat && pwdata[gtc_pkg::STAT_OVF_BIT];

  ////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one feeds stage two only
  assign raw_in[gtc_pkg::SYNC_PIN] = ext_clock_pin;
  assign raw_in[gtc_pkg::SYNC_LF] = low_freq_internal_osc;
  assign raw_in[gtc_pkg::SYNC_GATE] = gate_input;

  genvar gi;
  generate
    for (gi = 0; gi < gtc_pkg::SYNC_BITS; gi++) begin : g_sync
      // Two flops, then a history flop for edge detection
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  // Extra pin stage only the synchronous path uses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_s4 <= 1'b0;
    else pin_s4 <= sync3[gtc_pkg::SYNC_PIN];
  end

  ////////////////////////////////////////////////////////////////
  // Edge detection and source selection
  wire pin_s;
  wire pin_d;
  wire pin_rise;
  wire pin_fall;
  wire lf_rise;
  wire gate_s;
  wire instr_tick;
  wire gate_ok;
  wire async_ext;
  wire sleep_hold;
  wire count_en;
  wire src_tick;
  wire presc_tick;
  wire inc;
  wire wrap;
  wire [15:0] next_count;
  wire next_armed;
  wire next_ovf;
  wire [7:0] lo_view;
  wire [31:0] next_prdata;

  // Bypass skips one pin stage; a mode switch may lose or add a count
  assign pin_s = ctrl.sync_dis ? sync2[gtc_pkg::SYNC_PIN]
                               : sync3[gtc_pkg::SYNC_PIN];
  assign pin_d = ctrl.sync_dis ? sync3[gtc_pkg::SYNC_PIN] : pin_s4;
  assign pin_rise = pin_s && !pin_d;
  assign pin_fall = !pin_s && pin_d;
  assign lf_rise = sync2[gtc_pkg::SYNC_LF] && !sync3[gtc_pkg::SYNC_LF];
  assign gate_s = sync2[gtc_pkg::SYNC_GATE];
  assign instr_tick = (div4 == gtc_pkg::INSTR_DIV_LAST);

  // Gate level that allows counting follows the polarity bit
  assign gate_ok = !gate.gate_en || (gate_s == gate.gate_pol);
  // Only the unsynchronised pin source keeps running in sleep
  assign async_ext = ctrl.sync_dis && (ctrl.src == gtc_pkg::GTC_SRC_PIN);
  assign sleep_hold = sleep_mode && !async_ext;
  assign count_en = ctrl.run && gate_ok && !sleep_hold;

  // Source tick selected by the source field
  assign src_tick = (ctrl.src == gtc_pkg::GTC_SRC_LFOSC) ? lf_rise :
                    (ctrl.src == gtc_pkg::GTC_SRC_PIN) ? (pin_rise && armed) :
                    (ctrl.src == gtc_pkg::GTC_SRC_SYS) ? 1'b1 :
                    instr_tick;

  // Prescaler output is still gated so a late tick is not counted
  assign inc = presc_tick && count_en && !cnt_wr;
  assign wrap = inc && (count == gtc_pkg::CNT_MAX);

  // Byte writes replace the live byte and win over an increment
  assign next_count = lo_wr ? {count[15:8], pwdata[7:0]} :
                      hi_wr ? {pwdata[7:0], count[7:0]} :
                      inc ? count + 16'h0001 : count;

  // Writes or a stopped counter disarm; a falling pin edge re-arms
  assign next_armed = (cnt_wr || !count_en) ? 1'b0 :
                      pin_fall ? 1'b1 : armed;

  // Rollover set wins over a software clear in the same cycle
  assign next_ovf = wrap || (overflow_flag && !ovf_clr);

  // Low byte reads lose two bits when the sys or lfosc source drives the count
  assign lo_view = ((ctrl.src == gtc_pkg::GTC_SRC_SYS) ||
                    (ctrl.src == gtc_pkg::GTC_SRC_LFOSC)) ?
                   (count[7:0] & gtc_pkg::LSB_LOSS_MASK) : count[7:0];

  // Read mux, unmapped reads return zero
  assign next_prdata = hit_lo ? {24'h000000, lo_view} :
                       hit_hi ? {24'h000000, count[15:8]} :
                       hit_ctrl ? {24'h000000, ctrl} :
                       hit_gate ? {24'h000000, gate} :
                       hit_stat ? {30'h0, armed, overflow_flag} :
                       32'h00000000;

  ////////////////////////////////////////////////////////////////
  // Prescaler, cleared by any count byte write
  gtc_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(src_tick && count_en),
    .clear(cnt_wr),
    .sel(ctrl.presc),
    .tick_out(presc_tick)
  );

  ////////////////////////////////////////////////////////////////
  // APB answer: one wait state, data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_done;
      pslverr <= setup_done && !hit_any;
      if (setup_done && !pwrite) prdata <= next_prdata;
    end
  end

  // Control registers, written at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= gtc_pkg::CTRL_RESET;
      gate <= gtc_pkg::GATE_RESET;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        ctrl <= pwdata[7:0];
        ctrl.rsv <= 1'b0;
      end
      if (hit_gate) gate <= {pwdata[7:6], 6'h00};
    end
  end

  // Counter, arming and overflow state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= gtc_pkg::CNT_RESET;
      armed <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      count <= next_count;
      armed <= next_armed;
      overflow_flag <= next_ovf;
    end
  end

  // Instruction clock divider, free running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div4 <= 2'h0;
    else div4 <= div4 + 2'h1;
  end

  // Wake and oscillator outputs; the oscillator ignores sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
      secondary_osc_enable <= 1'b0;
    end else begin
      wake_req <= sleep_mode && next_ovf;
      secondary_osc_enable <= ctrl.osc_en;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovf_rollover: assert property (wrap |=> overflow_flag && count == 16'h0000)
    else $error("rollover did not set flag and wrap count");
  a_ovf_sticky: assert property (overflow_flag && !ovf_clr |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  a_run_off: assert property (!ctrl.run && !cnt_wr |=> count == $past(count))
    else $error("count moved with run bit clear");
  a_gate_hold: assert property (ctrl.run && gate.gate_en && gate_s != gate.gate_pol
      && !cnt_wr |=> $stable(count))
    else $error("count moved while gate closed");
  a_instr_div: assert property (instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not every fourth clock");
  a_lo_write: assert property (lo_wr |=> count[7:0] == $past(pwdata[7:0]))
    else $error("low byte write not taken");
  a_hi_write: assert property (hi_wr |=> count[15:8] == $past(pwdata[7:0]))
    else $error("high byte write not taken");
  a_lsb_loss: assert property (setup_done && !pwrite && hit_lo &&
      ctrl.src == gtc_pkg::GTC_SRC_SYS |=> prdata[1:0] == 2'b00)
    else $error("low bits visible with system clock source");
  a_disarm_write: assert property (cnt_wr |=> !armed)
    else $error("count write left pin path armed");
  a_sleep_hold: assert property (sleep_mode && !async_ext && !cnt_wr
      |=> $stable(count))
    else $error("synchronous count moved in sleep");
  a_apb_ready: assert property (setup_done |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

  c_rollover: cover property (wrap);
  c_gated_count: cover property (gate.gate_en && inc);
  c_async_pin: cover property (async_ext && sleep_mode && inc);

endmodule : gtc_timer_core

// file: hw/gtc_pkg.sv
// How it works
// - 16-bit count, byte writes replace live bytes
// - Run off stops; gate-enable adds gate check
// - Source field picks instr/sys/pin/lfosc clock
// - Sys or lfosc source counts every rising edge
// - Instruction source counts every fourth clock
// - Sys/lfosc reads lose two low bits
// - Pin source counts pin rising edge, prescaled
// - Sync-disable bypasses the extra sync stage
// - Falling edge arms counting after write/disable
// - Prescale field divides by 1, 2, 4, 8
// - Prescaler hidden, cleared on count writes
// - Osc-enable bit runs secondary oscillator
// - Async pin counting continues during sleep
// - Byte reads valid while pin clock runs
// - Gate input qualifies counting
// - Rollover sets sticky overflow flag
// - Gate polarity picks counting gate level
package gtc_pkg;

  ////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB
  localparam logic [7:0] ADDR_CNT_LO = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_GATE = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  ////////////////////////////////////////////////////////////////
  // Clock source encodings
  typedef enum logic [1:0] {
    GTC_SRC_INSTR = 2'b00,
    GTC_SRC_SYS = 2'b01,
    GTC_SRC_PIN = 2'b10,
    GTC_SRC_LFOSC = 2'b11
  } gtc_src_t;

  // Timer control register layout
  typedef struct packed {
    gtc_src_t src;      // Clock source field
    logic [1:0] presc;  // Prescale field
    logic osc_en;       // Secondary oscillator enable
    logic sync_dis;     // Sync-disable bit
    logic rsv;          // Reads as zero
    logic run;          // Run bit
  } gtc_ctrl_t;

  // Gate control register layout
  typedef struct packed {
    logic gate_en;      // Gate-enable bit
    logic gate_pol;     // Gate polarity bit
    logic [5:0] rsv;    // Reads as zero
  } gtc_gate_t;

  ////////////////////////////////////////////////////////////////
  // Reset values and constants
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [7:0] LSB_LOSS_MASK = 8'hFC;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam int unsigned STAT_OVF_BIT = 0;
  localparam int unsigned STAT_ARM_BIT = 1;
  localparam int unsigned SYNC_BITS = 3;
  localparam int unsigned SYNC_PIN = 0;
  localparam int unsigned SYNC_LF = 1;
  localparam int unsigned SYNC_GATE = 2;

endpackage : gtc_pkg

// file: hw/gtc_prescaler.sv
`timescale 1ns/1ps
// Divides a tick stream by 1, 2, 4 or 8
module gtc_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] sel,
  // Divided tick
  output logic tick_out
);

  logic [2:0] cnt; // Hidden prescale counter
  wire [2:0] mask;
  wire hit;

  // Low bits that must all be one to pass a tick
  function automatic logic [2:0] div_mask(input logic [1:0] s);
    logic [2:0] m;
    m = 3'h0;
    if (s == 2'h1) m = 3'h1;
    else if (s == 2'h2) m = 3'h3;
    else if (s == 2'h3) m = 3'h7;
    return m;
  endfunction : div_mask

  assign mask = div_mask(sel);
  assign hit = tick_in && ((cnt & mask) == mask);

  ////////////////////////////////////////////////////////////////
  // Counter; a count write clears it and drops a pending tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= gtc_pkg::PRESC_RESET;
      tick_out <= 1'b0;
    end else if (clear) begin
      cnt <= gtc_pkg::PRESC_RESET;
      tick_out <= 1'b0;
    end else begin
      if (tick_in) cnt <= cnt + 3'h1;
      tick_out <= hit;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_presc_clear: assert property (clear |=> cnt == gtc_pkg::PRESC_RESET)
    else $error("prescaler not cleared by count write");
  a_presc_div2: assert property ((sel == 2'h1 && tick_in && !cnt[0] && !clear)
      |=> !tick_out)
    else $error("divide by two passed an odd tick");

endmodule : gtc_prescaler

// file: tb/gtc_clk_model.sv
`timescale 1ns/1ps
// Far side: external pin clock source and low-frequency oscillator
module gtc_clk_model (
  // Clock
  input wire logic pclk,
  // Burst request from the bench
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [2:0] half,
  // Clock outputs toward the core
  output logic ext_clock_pin,
  output logic low_freq_internal_osc,
  output logic busy
);
  int lf_cnt; // Oscillator phase counter

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running oscillator, period 16 pclk, unrelated to bursts
  // One process owns the oscillator state, start values included
  initial begin
    lf_cnt = 0;
    low_freq_internal_osc = 1'b0;
    forever begin
      @(posedge pclk);
      lf_cnt <= (lf_cnt == 7) ? 0 : lf_cnt + 1;
      if (lf_cnt == 7) begin
        low_freq_internal_osc <= ~low_freq_internal_osc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin bursts; pin rests low between bursts so no stray edge is seen
  initial begin
    ext_clock_pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (start) begin
        busy <= 1'b1;
        // Half periods of two or more pclk keep within the sampling rate
        repeat (pulses) begin
          ext_clock_pin <= 1'b1;
          repeat (half) @(posedge pclk);
          ext_clock_pin <= 1'b0;
          repeat (half) @(posedge pclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : gtc_clk_model

// file: tb/gtc_timer_core_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the gated timer core
module gtc_timer_core_tb;
  logic pclk = 1'b0; // 25 MHz clock
  logic presetn = 1'b0; // Held low for five cycles
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic gate_input = 1'b0, sleep_mode = 1'b0, start = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic [2:0] half = 3'h2;
  logic ext_clock_pin, low_freq_internal_osc, busy;
  logic overflow_flag, wake_req, secondary_osc_enable;
  int error_cnt = 0, checks_done = 0, seed = 58;
  logic [31:0] rd, c, v; // Read data, count, random value
  logic err;
  int n;

  always #20 pclk = ~pclk;

  gtc_timer_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
    .low_freq_internal_osc(low_freq_internal_osc), .gate_input(gate_input),
    .sleep_mode(sleep_mode), .overflow_flag(overflow_flag), .wake_req(wake_req),
    .secondary_osc_enable(secondary_osc_enable));

  gtc_clk_model model_u (.pclk(pclk), .start(start), .pulses(pulses), .half(half),
    .ext_clock_pin(ext_clock_pin), .low_freq_internal_osc(low_freq_internal_osc),
    .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare with a tolerance; a sync pipeline shifts window edges slightly
  task chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic [31:0] d;
    begin
      d = (got > exp) ? got - exp : exp - got;
      checks_done++;
      if (^got === 1'bx || d > tol) begin
        error_cnt++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    begin
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
        k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) error_cnt++;
    end
  endtask : apb

  // Count read as two bytes; only used while the counter is stopped
  task rd_cnt;
    begin
      apb(1'b0, gtc_pkg::ADDR_CNT_LO, 8'h00);
      c[7:0] = rd[7:0];
      apb(1'b0, gtc_pkg::ADDR_CNT_HI, 8'h00);
      c = {16'h0000, rd[7:0], c[7:0]};
    end
  endtask : rd_cnt

  task clr_cnt;
    begin
      apb(1'b1, gtc_pkg::ADDR_CNT_LO, 8'h00);
      apb(1'b1, gtc_pkg::ADDR_CNT_HI, 8'h00);
    end
  endtask : clr_cnt

  // Pin burst of p pulses, then let the sync pipeline drain
  task burst(input int p);
    int k;
    begin
      k = 0;
      pulses <= p[7:0];
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1 && k < 2000) begin
        @(posedge pclk);
        k++;
      end
      repeat (8) @(posedge pclk);
    end
  endtask : burst

  // Expected count after cyc pclk with source s and prescale p
  function logic [31:0] exp_cnt(input logic [1:0] s, input logic [1:0] p, input int cyc);
    logic [31:0] e;
    begin
      e = cyc / ((s == 2'b00) ? 4 : (s == 2'b11) ? 16 : 1) / (1 << p);
      if (s == 2'b01 || s == 2'b11) e[1:0] = 2'b00;
      return e;
    end
  endfunction : exp_cnt

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the roughly 9.4k cycles of the sequence
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 8'h00);
      chk(rd, 32'h0, 0);
    end
    apb(1'b0, 8'h14, 8'h00);
    chk({31'h0, err}, 32'h1, 0);
    $display("test reset done");
    // Random byte writes land in the live count
    repeat (4) begin
      v = $random(seed);
      apb(1'b1, gtc_pkg::ADDR_CNT_LO, v[7:0]);
      apb(1'b1, gtc_pkg::ADDR_CNT_HI, v[15:8]);
      rd_cnt();
      chk(c, {16'h0000, v[15:0]}, 0);
    end
    // Control fields, reserved bit reads zero, oscillator enable output
    apb(1'b1, gtc_pkg::ADDR_CTRL, 8'h3E);
    apb(1'b0, gtc_pkg::ADDR_CTRL, 8'h00);
    chk(rd, 32'h3C, 0);
    chk({31'h0, secondary_osc_enable}, 32'h1, 0);
    apb(1'b1, gtc_pkg::ADDR_GATE, 8'hFF);
    apb(1'b0, gtc_pkg::ADDR_GATE, 8'h00);
    chk(rd, 32'hC0, 0);
    apb(1'b1, gtc_pkg::ADDR_GATE, 8'h00);
    $display("test fields done");
    // Every source except the pin, every prescale, fixed window
    for (int i = 0; i < 16; i++) begin
      if (i[3:2] != 2'b10) begin
        clr_cnt();
        apb(1'b1, gtc_pkg::ADDR_CTRL, {i[3:0], 4'h1});
        repeat (512) @(posedge pclk);
        apb(1'b1, gtc_pkg::ADDR_CTRL, {i[3:0], 4'h0});
        rd_cnt();
        chk(c, exp_cnt(i[3:2], i[1:0], 515), 4);
      end
    end
    $display("test sources done");
    // Run, gate enable, polarity and gate level in all combinations
    for (int i = 0; i < 16; i++) begin
      gate_input <= i[0];
      apb(1'b1, gtc_pkg::ADDR_GATE, {i[2:1], 6'h00});
      clr_cnt();
      apb(1'b1, gtc_pkg::ADDR_CTRL, {7'h20, i[3]});
      repeat (64) @(posedge pclk);
      apb(1'b1, gtc_pkg::ADDR_CTRL, 8'h40);
      rd_cnt();
      v = (i[3] && (!i[2] || i[1] == i[0])) ? exp_cnt(2'b01, 2'b00, 67) : 32'h0;
      chk(c, v, 4);
    end
    apb(1'b1, gtc_pkg::ADDR_GATE, 8'h00);
    $display("test gate done");
    // Pin source: first rise after a count write is skipped; sleep per mode
    for (int i = 0; i < 4; i++) begin
      n = 3 + ($random(seed) & 7);
      half <= i[0] ? 3'h2 : 3'h5;
      clr_cnt();
      apb(1'b1, gtc_pkg::ADDR_CTRL, {5'h10, i[0], 2'b01});
      sleep_mode <= i[1];
      burst(n);
      sleep_mode <= 1'b0;
      apb(1'b1, gtc_pkg::ADDR_CTRL, 8'h80);
      rd_cnt();
      chk(c, (i[0] || !i[1]) ? n - 1 : 0, 0);
    end
    $display("test pin done");
    // Start-up wait: preload FC00, flag after 1024 counts, sticky, wake
    apb(1'b1, gtc_pkg::ADDR_STAT, 8'h01);
    apb(1'b1, gtc_pkg::ADDR_CNT_LO, 8'h00);
    apb(1'b1, gtc_pkg::ADDR_CNT_HI, 8'hFC);
    apb(1'b1, gtc_pkg::ADDR_CTRL, 8'h41);
    n = 0;
    while (overflow_flag !== 1'b1 && n < 1100) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 32'd1024, 4);
    apb(1'b1, gtc_pkg::ADDR_CTRL, 8'h00);
    apb(1'b0, gtc_pkg::ADDR_STAT, 8'h00);
    chk({31'h0, rd[0]}, 32'h1, 0);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, wake_req}, 32'h1, 0);
    sleep_mode <= 1'b0;
    apb(1'b1, gtc_pkg::ADDR_STAT, 8'h01);
    apb(1'b0, gtc_pkg::ADDR_STAT, 8'h00);
    chk({31'h0, rd[0]}, 32'h0, 0);
    $display("test overflow done");
    finish_test();
  end
endmodule : gtc_timer_core_tb
